// [design/aqc_pkg.sv]
package aqc_pkg;

	// Register byte offsets on the bus.
	localparam logic [5:0] ADR_RESULT = 6'h00;
	localparam logic [5:0] ADR_SWTRIG = 6'h04;
	localparam logic [5:0] ADR_MUX    = 6'h08;
	localparam logic [5:0] ADR_MODE   = 6'h0C;
	localparam logic [5:0] ADR_GAIN   = 6'h10;
	localparam logic [5:0] ADR_STATUS = 6'h14;
	localparam logic [5:0] ADR_DIV1   = 6'h18;
	localparam logic [5:0] ADR_DIV2   = 6'h1C;
	localparam logic [5:0] ADR_COUNT  = 6'h20;

	// Mode register fields.
	localparam int MODE_SRC_LO           = 0;
	localparam int MODE_SRC_HI           = 1;
	localparam int MODE_AUTO_SCAN_ENABLE = 2;
	localparam int MODE_EOC_IRQ_EN       = 3;
	localparam int MODE_HALF_IRQ_EN      = 4;
	localparam int MODE_EXT_OUT_EN       = 5;

	// Status register fields.
	localparam int STB_BUFFER_NOT_EMPTY_FLAG = 0;
	localparam int STB_CONVERTER_IDLE_FLAG   = 1;
	localparam int STB_IRQ                   = 2;
	localparam int STB_FULL                  = 3;
	localparam int STB_HALF                  = 4;

	// Reset values.
	localparam logic [7:0]  MUX_RST  = 8'h00;
	localparam logic [7:0]  MODE_RST = 8'h00;
	localparam logic [2:0]  GAIN_RST = 3'h0;
	localparam logic [15:0] DIV_RST  = 16'h0002;

	// Gain codes 0..4 select gains 1, 2, 4, 8 and 16.
	localparam logic [2:0] GAIN_MAX = 3'h4;

	// Buffer geometry.
	localparam int          FIFO_AW    = 10;
	localparam logic [10:0] FIFO_DEPTH = 11'h400;
	localparam logic [10:0] HALF_WORDS = 11'h200;

	// Result word carries the channel number in its low nibble.
	localparam logic VARIANT_12 = 1'b1;

	// Longest conversion time, rounded down to whole cycles.
	localparam int unsigned CLK_PERIOD_PS = 10000;
	localparam int unsigned CONV_MAX_PS   = 8500000;
	localparam int unsigned CONV_MAX_CYC  = CONV_MAX_PS / CLK_PERIOD_PS;
	localparam int          TMR_W         = 10;
	localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_MAX_CYC - 1);

	typedef enum logic [1:0] {
		SRC_SW    = 2'h0,
		SRC_TIMER = 2'h1,
		SRC_EXT   = 2'h2
	} aqc_src_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} aqc_state_t;

endpackage

// [design/aqc_fifo_if.sv]
`timescale 1ns/1ps
interface aqc_fifo_if;
	logic        push;
	logic [15:0] wdata;
	logic        pop;
	logic [15:0] head;
	logic [10:0] count;
	modport src   (output push, output wdata, output pop, input head, input count);
	modport store (input push, input wdata, input pop, output head, output count);
endinterface

// [design/aqc_fifo.sv]
`timescale 1ns/1ps
module aqc_fifo (
	// Clock, reset and freeze.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Result stream.
	aqc_fifo_if.store f
);
	import aqc_pkg::*;

	typedef struct packed {
		logic [FIFO_AW-1:0] wp;
		logic [FIFO_AW-1:0] rp;
		logic [10:0]        cnt;
	} aqc_fifo_s_t;

	aqc_fifo_s_t q;
	aqc_fifo_s_t n;
	logic [15:0] mem [0:1023];
	logic        wr;
	logic        rd;

	always_comb begin
		n = q;
		wr = f.push && (q.cnt != FIFO_DEPTH);
		rd = f.pop && (q.cnt != 11'h000);
		if (wr) begin
			n.wp = q.wp + 10'h001;
		end
		if (rd) begin
			n.rp = q.rp + 10'h001;
		end
		if (wr && !rd) begin
			n.cnt = q.cnt + 11'h001;
		end else if (rd && !wr) begin
			n.cnt = q.cnt - 11'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= n;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && wr) begin
			mem[q.wp] <= f.wdata;
		end
	end

	assign f.head  = mem[q.rp];
	assign f.count = q.cnt;
endmodule

// [design/aqc_pacer.sv]
`timescale 1ns/1ps
module aqc_pacer (
	// Clock, reset and freeze.
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Divisors and tick.
	input  wire logic        en,
	input  wire logic [15:0] div1,
	input  wire logic [15:0] div2,
	output logic             tick
);
	import aqc_pkg::*;

	typedef struct packed {
		logic [15:0] c1;
		logic [15:0] c2;
		logic        tick;
	} aqc_pacer_s_t;

	aqc_pacer_s_t q;
	aqc_pacer_s_t n;

	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (!en) begin
			n.c1 = div1 - 16'h0001;
			n.c2 = div2 - 16'h0001;
		end else if (q.c1 == 16'h0000) begin
			n.c1 = div1 - 16'h0001;
			if (q.c2 == 16'h0000) begin
				n.c2 = div2 - 16'h0001;
				n.tick = 1'b1;
			end else begin
				n.c2 = q.c2 - 16'h0001;
			end
		end else begin
			n.c1 = q.c1 - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= n;
		end
	end

	assign tick = q.tick;
endmodule

// [design/aqc_top.sv]
// Contract
// - Start one conversion on each event of the selected trigger that arrives while the converter is idle.
// - Sixteen single-ended inputs share one gain setting.
// - Auto-scan off: convert only the channel held in the multiplexer register.
// - Auto-scan on: channel steps 0 to the multiplexer low nibble, then wraps.
// - Multiplexer register is 8 bits; high nibble can drive the extended pins.
// - The 12-bit variant returns the channel number in the result word.
// - 12-bit result in the upper twelve bits, channel in the low four.
// - Gain accepts exactly five levels: 1, 2, 4, 8 and 16.
// - Three trigger sources: software write, timer pacer, external input.
// - Software mode: any write to the trigger register while the converter is idle starts a conversion.
// - Timer mode: two cascaded counters make periodic triggers.
// - External mode: a high-to-low input change starts a conversion.
// - Trigger source and each interrupt source are set independently.
// - Results are buffered in a 1024-word first-in first-out store.
// - A result arriving at a full buffer is discarded.
// - Results enter the buffer on completion; not-empty flag follows occupancy.
// - Idle flag is low during conversion and high after it.
// - Every conversion completes within 8.5 microseconds of its trigger.
// - Half-full interrupt fires when the buffer reaches 512 words.
`timescale 1ns/1ps
module aqc_top (
	// Clock, reset and freeze.
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        CE,

	// Avalon-MM slave.
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,

	// Converter front end.
	output logic             ADC_START,
	output logic [3:0]       ADC_CHAN,
	output logic [2:0]       ADC_GAIN,
	input  wire logic        ADC_DONE,
	input  wire logic [15:0] ADC_DATA,

	// Pins and interrupt.
	input  wire logic        EXTERNAL_TRIGGER_INPUT,
	output logic [3:0]       EXTENDED_OUTPUT_PINS,
	output logic             IRQ
);
	import aqc_pkg::*;

	typedef struct packed {
		logic              wreq;
		logic              ack;
		logic [31:0]       rdata;
		logic [7:0]        mux;
		logic [7:0]        mode;
		logic [2:0]        gain;
		logic [15:0]       div1;
		logic [15:0]       div2;
		logic              swtrig;
		logic              ext_prev;
		aqc_state_t        state;
		logic [TMR_W-1:0]  tmr;
		logic [3:0]        chan;
		logic [3:0]        scan;
		logic              start;
		logic              half_prev;
		logic              irq;
		logic [3:0]        ext_out;
	} aqc_top_s_t;

	localparam aqc_top_s_t S_RST = '{
		wreq:     1'b1,
		mux:      MUX_RST,
		mode:     MODE_RST,
		gain:     GAIN_RST,
		div1:     DIV_RST,
		div2:     DIV_RST,
		ext_prev: 1'b1,
		state:    ST_IDLE,
		default:  '0
	};

	aqc_top_s_t  q;
	aqc_top_s_t  n;
	aqc_fifo_if  f ();
	logic        tick;
	aqc_src_t    src;
	logic        trig;
	logic        done;
	logic        half_now;
	logic        hf_evt;
	logic        irq_set;
	logic        irq_clr;
	logic [31:0] wmerged;
	logic [31:0] status;
	logic [31:0] m_mux;
	logic [31:0] m_mode;
	logic [31:0] m_div1;
	logic [31:0] m_div2;

	// Merges write data into an old word, one byte lane at a time.
	function automatic logic [31:0] aqc_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Occupancy tests shared by the status word, the pop and the interrupt.
	function automatic logic aqc_has_data(input logic [10:0] cnt);
		return cnt != 11'h000;
	endfunction

	function automatic logic aqc_at_half(input logic [10:0] cnt);
		return cnt >= HALF_WORDS;
	endfunction

	// The store and the pacer share the clock enable with the rest of the block.
	aqc_fifo u_fifo (
		.clk (CLK),
		.rst (RESET),
		.ce  (CE),
		.f   (f.store)
	);

	aqc_pacer u_pacer (
		.clk  (CLK),
		.rst  (RESET),
		.ce   (CE),
		.en   (src == SRC_TIMER),
		.div1 (q.div1),
		.div2 (q.div2),
		.tick (tick)
	);

	always_comb begin
		n = q;
		n.swtrig = 1'b0;
		n.start = 1'b0;
		n.ext_prev = EXTERNAL_TRIGGER_INPUT;
		f.pop = 1'b0;
		f.push = 1'b0;
		f.wdata = 16'h0000;
		trig = 1'b0;
		done = 1'b0;
		irq_clr = 1'b0;
		wmerged = aqc_merge(32'h00000000, AVS_WRITEDATA, AVS_BYTEENABLE);
		src = aqc_src_t'(q.mode[MODE_SRC_HI:MODE_SRC_LO]);

		// Partial writes keep the bytes whose lanes are off.
		m_mux = aqc_merge({24'h000000, q.mux}, AVS_WRITEDATA, AVS_BYTEENABLE);
		m_mode = aqc_merge({24'h000000, q.mode}, AVS_WRITEDATA, AVS_BYTEENABLE);
		m_div1 = aqc_merge({16'h0000, q.div1}, AVS_WRITEDATA, AVS_BYTEENABLE);
		m_div2 = aqc_merge({16'h0000, q.div2}, AVS_WRITEDATA, AVS_BYTEENABLE);

		// Status word assembled from live state.
		status = 32'h00000000;
		status[STB_BUFFER_NOT_EMPTY_FLAG] = aqc_has_data(f.count);
		status[STB_CONVERTER_IDLE_FLAG] = (q.state == ST_IDLE);
		status[STB_IRQ] = q.irq;
		status[STB_FULL] = (f.count == FIFO_DEPTH);
		status[STB_HALF] = aqc_at_half(f.count);

		// Bus slave: one wait cycle, then the answer.
		if (q.ack) begin
			n.ack = 1'b0;
			n.wreq = 1'b1;
		end else if (AVS_READ || AVS_WRITE) begin
			n.ack = 1'b1;
			n.wreq = 1'b0;
			n.rdata = 32'h00000000;
			if (AVS_READ) begin
				case (AVS_ADDRESS)
					ADR_RESULT: begin
						n.rdata = {16'h0000, f.head};
						f.pop = aqc_has_data(f.count);
					end
					ADR_MUX: begin
						n.rdata = {24'h000000, q.mux};
					end
					ADR_MODE: begin
						n.rdata = {24'h000000, q.mode};
					end
					ADR_GAIN: begin
						n.rdata = {29'h00000000, q.gain};
					end
					ADR_STATUS: begin
						n.rdata = status;
					end
					ADR_DIV1: begin
						n.rdata = {16'h0000, q.div1};
					end
					ADR_DIV2: begin
						n.rdata = {16'h0000, q.div2};
					end
					ADR_COUNT: begin
						n.rdata = {21'h000000, f.count};
					end
					default: begin
						n.rdata = 32'h00000000;
					end
				endcase
			end else begin
				case (AVS_ADDRESS)
					ADR_SWTRIG: begin
						n.swtrig = 1'b1;
					end
					ADR_MUX: begin
						n.mux = m_mux[7:0];
					end
					ADR_MODE: begin
						n.mode = m_mode[7:0];
					end
					ADR_GAIN: begin
						if (AVS_BYTEENABLE[0] && wmerged[2:0] <= GAIN_MAX) begin
							n.gain = wmerged[2:0];
						end
					end
					ADR_STATUS: begin
						irq_clr = AVS_BYTEENABLE[0] && AVS_WRITEDATA[STB_IRQ];
					end
					ADR_DIV1: begin
						n.div1 = m_div1[15:0];
					end
					ADR_DIV2: begin
						n.div2 = m_div2[15:0];
					end
					default: begin
						n.rdata = 32'h00000000;
					end
				endcase
			end
		end

		// Only the selected source may trigger.
		case (src)
			SRC_SW: begin
				trig = q.swtrig;
			end
			SRC_TIMER: begin
				trig = tick;
			end
			SRC_EXT: begin
				trig = q.ext_prev && !EXTERNAL_TRIGGER_INPUT;
			end
			default: begin
				trig = 1'b0;
			end
		endcase

		// Conversion sequencer.
		case (q.state)
			ST_IDLE: begin
				if (trig) begin
					n.state = ST_CONV;
					n.tmr = '0;
					n.start = 1'b1;
					if (q.mode[MODE_AUTO_SCAN_ENABLE]) begin
						n.chan = q.scan;
						if (q.scan >= q.mux[3:0]) begin
							n.scan = 4'h0;
						end else begin
							n.scan = q.scan + 4'h1;
						end
					end else begin
						n.chan = q.mux[3:0];
					end
				end
			end
			ST_CONV: begin
				if (ADC_DONE || q.tmr == CONV_LAST) begin
					done = 1'b1;
					n.state = ST_IDLE;
				end else begin
					n.tmr = q.tmr + 10'h001;
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase

		if (!q.mode[MODE_AUTO_SCAN_ENABLE]) begin
			n.scan = 4'h0;
		end

		// Completed result goes straight into the buffer.
		if (done) begin
			f.push = 1'b1;
			if (VARIANT_12) begin
				f.wdata = {ADC_DATA[15:4], q.chan};
			end else begin
				f.wdata = ADC_DATA;
			end
		end

		// Interrupt on end of conversion or on reaching half-full.
		half_now = aqc_at_half(f.count);
		n.half_prev = half_now;
		hf_evt = half_now && !q.half_prev;
		irq_set = (done && q.mode[MODE_EOC_IRQ_EN])
			|| (hf_evt && q.mode[MODE_HALF_IRQ_EN]);
		n.irq = irq_set || (q.irq && !irq_clr);

		if (q.mode[MODE_EXT_OUT_EN]) begin
			n.ext_out = q.mux[7:4];
		end else begin
			n.ext_out = 4'h0;
		end
	end

	// All state sits in one register stage; CE low freezes it.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			q <= S_RST;
		end else if (CE) begin
			q <= n;
		end
	end

	// Every output is read straight from the state register.
	assign AVS_READDATA         = q.rdata;
	assign AVS_WAITREQUEST      = q.wreq;
	assign ADC_START            = q.start;
	assign ADC_CHAN             = q.chan;
	assign ADC_GAIN             = q.gain;
	assign EXTENDED_OUTPUT_PINS = q.ext_out;
	assign IRQ                  = q.irq;
endmodule

// [tb/aqc_checker.sv]
`timescale 1ns/1ps
module aqc_checker
	import aqc_pkg::*;
(
	// Clock and reset.
	input wire logic        CLK,
	input wire logic        RESET,
	// Register bus.
	input wire logic [5:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	// Converter and interrupt.
	input wire logic        ADC_START,
	input wire logic [3:0]  ADC_CHAN,
	input wire logic [2:0]  ADC_GAIN,
	input wire logic        ADC_DONE,
	input wire logic        IRQ
);
	logic [10:0] run_q;
	logic [10:0] run_d;
	logic        clr;
	// Counts cycles of the conversion in flight.
	always_comb begin
		run_d = run_q;
		if (ADC_START)
			run_d = 11'h001;
		else if (run_q != 11'h000 && ADC_DONE)
			run_d = 11'h000;
		else if (run_q != 11'h000)
			run_d = run_q + 11'h001;
	end
	always_ff @(posedge CLK) begin
		if (RESET)
			run_q <= 11'h000;
		else
			run_q <= run_d;
	end
	assign clr = AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == ADR_STATUS
		&& AVS_WRITEDATA[STB_IRQ];
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	property p_answer;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
	endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_wait_one;
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer too long");
	property p_start;
		ADC_START |=> !ADC_START;
	endproperty
	a_start: assert property (p_start) else $error("start not a pulse");
	property p_chan;
		$changed(ADC_CHAN) |-> ADC_START;
	endproperty
	a_chan: assert property (p_chan) else $error("channel moved without start");
	property p_gain;
		ADC_GAIN <= GAIN_MAX;
	endproperty
	a_gain: assert property (p_gain) else $error("gain code out of range");
	property p_irq_clr;
		IRQ && !clr |=> IRQ;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq dropped alone");
	property p_result;
		AVS_READ && AVS_ADDRESS == ADR_RESULT && !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0;
	endproperty
	a_result: assert property (p_result) else $error("result upper half set");
	property p_one_conv;
		ADC_START |-> run_q == 11'h000 || run_q > 11'h351;
	endproperty
	a_one_conv: assert property (p_one_conv) else $error("start during conversion");
endmodule
bind aqc_top aqc_checker u_chk (
	.CLK(CLK),
	.RESET(RESET),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.ADC_START(ADC_START),
	.ADC_CHAN(ADC_CHAN),
	.ADC_GAIN(ADC_GAIN),
	.ADC_DONE(ADC_DONE),
	.IRQ(IRQ)
);

// [tb/aqc_adc_model.sv]
`timescale 1ns/1ps
module aqc_adc_model (
	// Clock and request.
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic        slow,
	// Result.
	output logic             done,
	output logic [15:0]      data
);
	logic [11:0] n_q = 12'h000;
	int          w   = 0;
	initial done = 1'b0;
	initial data = 16'h0000;
	// Data lines toggle outside the completion cycle.
	always @(posedge clk) begin
		done <= 1'b0;
		data <= ~data;
		if (start)
			w <= slow ? 40 : 3;
		else if (w > 0) begin
			w <= w - 1;
			if (w == 1) begin
				done <= 1'b1;
				data <= {n_q, 4'hA};
				n_q <= n_q + 12'h001;
			end
		end
	end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import aqc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  adr = 6'h00;
	logic        rde = 1'b0;
	logic        wre = 1'b0;
	logic [31:0] wd  = 32'h0;
	logic [31:0] rdata;
	logic        wait_r;
	logic        start;
	logic [3:0]  chan;
	logic [2:0]  gain;
	logic        done;
	logic [15:0] data;
	logic        ext = 1'b1;
	logic [3:0]  pins;
	logic        irq;
	logic        slow = 1'b0;
	logic [7:0]  rnd = 8'h49;
	logic [31:0] r;
	logic [5:0]  ra[7] = '{ADR_MUX, ADR_MODE, ADR_GAIN, ADR_DIV1, ADR_STATUS, ADR_COUNT, 6'h3C};
	logic [31:0] rv[7] = '{0, 0, 0, 2, 2, 0, 0};
	int          mismatches = 0;
	int          total_checks = 0;
	int          ndone = 0;
	int          cyc = 0;
	int          base;
	int          st[$];
	always #5 clk = ~clk;
	aqc_top dut (
		.CLK(clk), .RESET(rst), .CE(1'b1),
		.AVS_ADDRESS(adr), .AVS_READ(rde), .AVS_WRITE(wre), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
		.ADC_START(start), .ADC_CHAN(chan), .ADC_GAIN(gain), .ADC_DONE(done),
		.ADC_DATA(data), .EXTERNAL_TRIGGER_INPUT(ext), .EXTENDED_OUTPUT_PINS(pins), .IRQ(irq)
	);
	aqc_adc_model adc (.clk(clk), .start(start), .slow(slow), .done(done), .data(data));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (done)
			ndone <= ndone + 1;
		if (start)
			st.push_back(cyc);
	end
	function automatic logic [7:0] lf(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic logic [31:0] res(input int k, input logic [3:0] c);
		return {16'h0, k[11:0], c};
	endfunction
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wre <= w;
		rde <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		r = rdata;
		if (n == 20)
			mismatches++;
		rde <= 1'b0;
		wre <= 1'b0;
		@(posedge clk);
	endtask
	task automatic idle();
		int n;
		n = 0;
		do begin
			bus(0, ADR_STATUS, 0);
			n++;
		end while (r[1] !== 1'b1 && n < 200);
		if (r[1] !== 1'b1)
			mismatches++;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i]) begin
			bus(0, ra[i], 0);
			chk("reset", r, rv[i]);
		end
		for (int g = 0; g < 8; g++) begin
			bus(1, ADR_GAIN, g);
			bus(0, ADR_GAIN, 0);
			chk("gain", r, g < 5 ? g : 4);
			chk("gain pin", gain, g < 5 ? g : 4);
		end
		$display("reset and gain done");
		rnd = lf(rnd);
		bus(1, ADR_MUX, rnd);
		base = ndone;
		slow <= 1'b1;
		bus(1, ADR_SWTRIG, rnd);
		bus(0, ADR_STATUS, 0);
		chk("busy", r[1:0], 0);
		idle();
		slow <= 1'b0;
		chk("ready", r[0], 1);
		for (int k = 0; k < 2; k++) begin
			bus(1, ADR_SWTRIG, 0);
			idle();
		end
		bus(1, ADR_MODE, 8'h08);
		bus(1, ADR_SWTRIG, 0);
		repeat (CONV_MAX_CYC) @(posedge clk);
		chk("eoc irq", irq, 1);
		bus(1, ADR_STATUS, 32'h4);
		chk("eoc clear", irq, 0);
		for (int k = 0; k < 4; k++) begin
			bus(0, ADR_RESULT, 0);
			chk("result", r, res(base + k, rnd[3:0]));
		end
		bus(0, ADR_STATUS, 0);
		chk("empty", r[0], 0);
		$display("software trigger done");
		rnd = lf(rnd);
		bus(1, ADR_MUX, {rnd[7:4], 4'h2});
		bus(1, ADR_MODE, 8'h24);
		chk("pins", pins, rnd[7:4]);
		base = ndone;
		for (int k = 0; k < 5; k++) begin
			bus(1, ADR_SWTRIG, 0);
			idle();
		end
		for (int k = 0; k < 5; k++) begin
			bus(0, ADR_RESULT, 0);
			chk("scan", r, res(base + k, 4'(k % 3)));
		end
		$display("auto scan done");
		bus(1, ADR_MODE, 8'h02);
		bus(1, ADR_MUX, 8'h05);
		base = ndone;
		ext <= 1'b0;
		bus(1, ADR_SWTRIG, 0);
		idle();
		ext <= 1'b1;
		bus(1, ADR_SWTRIG, 0);
		idle();
		bus(0, ADR_COUNT, 0);
		chk("ext count", r, 1);
		bus(0, ADR_RESULT, 0);
		chk("ext", r, res(base, 4'h5));
		chk("chan pin", chan, 4'h5);
		$display("external trigger done");
		bus(1, ADR_DIV1, 3);
		bus(1, ADR_DIV2, 4);
		base = st.size();
		bus(1, ADR_MODE, 8'h01);
		repeat (60) @(posedge clk);
		bus(1, ADR_MODE, 8'h03);
		chk("period", st[base + 2] - st[base + 1], 12);
		do begin
			bus(0, ADR_RESULT, 0);
			bus(0, ADR_STATUS, 0);
		end while (r[0] !== 1'b0 && cyc < 30000);
		if (r[0] !== 1'b0)
			mismatches++;
		$display("timer done");
		base = ndone;
		bus(1, ADR_DIV1, 1);
		bus(1, ADR_DIV2, 1);
		bus(1, ADR_MODE, 8'h11);
		for (int i = 0; i < 9000 && ndone < base + 1030; i++) @(posedge clk);
		bus(1, ADR_MODE, 8'h03);
		bus(0, ADR_COUNT, 0);
		chk("full", r, 1024);
		chk("irq", irq, 1);
		bus(1, ADR_STATUS, 32'h4);
		chk("irq clear", irq, 0);
		for (int k = 0; k < 512; k++) begin
			bus(0, ADR_RESULT, 0);
			chk("block", r, res(base + k, 4'h5));
		end
		bus(0, ADR_COUNT, 0);
		chk("half left", r, 512);
		for (int k = 512; k < 1024; k++) begin
			bus(0, ADR_RESULT, 0);
			chk("fifo", r, res(base + k, 4'h5));
		end
		bus(0, ADR_STATUS, 0);
		chk("drained", r[0], 0);
		$display("buffer done");
		summarize();
	end
endmodule
